// ===== logic/pic_core.sv
// eight-input priority interrupt controller with processor port
`timescale 1ns/100ps

// Overview of operation
// - port 0x20 write with bit4 starts initialisation
// - first word bit3: level or edge inputs
// - first word bit2: call interval 4 or 8
// - first word bit1: single or cascaded operation
// - first word bit0: fourth word expected or skipped
// - second word stores type bits 7..3
// - acknowledge drives base plus serviced level
// - cascade word never sent; skip it
// - fourth word bit4 selects special fully nested
// - fourth word bits 3,2: buffered, master role
// - fourth word bit1 selects automatic end-of-service
// - port 0x21 after initialisation loads mask
// - bits 4,3 zero: rotate, specific, end-of-service
// - specific bit makes bits 2..0 name level
// - third word; special mask needs enable bit
// - poll: next read returns highest pending level
// - readback selects in-service or request register

module pic_core (
  // clock, reset and clock enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // processor port
  input wire pic_pkg::pic_bus_type bus_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic buf_en_o,
  // request inputs and request to the processor
  input wire logic [7:0] request_input_i,
  output logic int_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  pic_pkg::pic_state_type state_q;
  pic_pkg::pic_cfg_type cfg_q;
  logic [7:0] mask_q;
  logic [7:0] irr_q;
  logic [7:0] prev_q;
  logic [7:0] in_service_register_q;
  logic [2:0] prio_q;
  logic special_mask_state_q;
  logic rot_aeoi_q;
  logic poll_q;
  logic readback_select_in_service_q;
  logic ack_phase_q;
  logic [2:0] ack_level_q;
  logic [7:0] data_q;
  logic oe_q;
  logic buf_q;
  logic int_q;

  // ----------------------------------------
  // port decode
  // ----------------------------------------
  logic wr_cmd;
  logic wr_data;
  logic rd_strobe;
  logic w1;
  logic op2;
  logic op3;
  logic ack1;
  logic ack2;
  logic [7:0] d;

  assign d = bus_i.data;
  assign wr_cmd = bus_i.sel & bus_i.wr & (bus_i.a0 == pic_pkg::PORT_CMD[0]);
  assign wr_data = bus_i.sel & bus_i.wr & (bus_i.a0 == pic_pkg::PORT_DATA[0]);
  assign rd_strobe = bus_i.sel & bus_i.rd;
  assign w1 = wr_cmd & d[pic_pkg::W1_ID];
  assign op2 = wr_cmd & ~d[pic_pkg::W1_ID] & ~d[pic_pkg::OP_SEL];
  assign op3 = wr_cmd & ~d[7] & ~d[pic_pkg::W1_ID] & d[pic_pkg::OP_SEL];
  assign ack1 = bus_i.ack & ~ack_phase_q;
  assign ack2 = bus_i.ack & ack_phase_q;

  // ----------------------------------------
  // priority resolution
  // ----------------------------------------
  // returns {found, level}; the level just above low has top priority
  function automatic logic [3:0] pic_top(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] k;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      k = low + 3'(i) + 3'h1;
      if (v[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction : pic_top

  logic [7:0] req_vec;
  logic [7:0] isr_eff;
  logic [3:0] top_req;
  logic [3:0] top_isr;
  logic [2:0] pos_req;
  logic [2:0] pos_isr;
  logic grant;

  assign req_vec = irr_q & ~mask_q;
  // special mask lets masked serviced levels stop blocking
  assign isr_eff = special_mask_state_q ? (in_service_register_q & ~mask_q) : in_service_register_q;
  assign top_req = pic_top(req_vec, prio_q);
  assign top_isr = pic_top(isr_eff, prio_q);
  assign pos_req = top_req[2:0] - prio_q - 3'h1;
  assign pos_isr = top_isr[2:0] - prio_q - 3'h1;
  // special fully nested lets an equal level through again
  assign grant = top_req[3] & (~top_isr[3] | (pos_req < pos_isr) |
                 (cfg_q.sfnm & (pos_req == pos_isr)));

  // ----------------------------------------
  // service events
  // ----------------------------------------
  logic serve;
  logic [7:0] set_isr;
  logic [7:0] clr_isr;
  logic [2:0] eoi_level;
  logic eoi_hit;

  // acknowledge or polled read both take the winning level
  assign serve = ack1 | (rd_strobe & poll_q);
  assign set_isr = (serve & grant) ? (8'h01 << top_req[2:0]) : 8'h00;
  assign eoi_level = d[pic_pkg::OP2_SL] ? d[2:0] : top_isr[2:0];
  assign eoi_hit = op2 & d[pic_pkg::OP2_EOI] & (d[pic_pkg::OP2_SL] | top_isr[3]);
  always_comb begin
    clr_isr = 8'h00;
    if (eoi_hit) begin
      clr_isr = 8'h01 << eoi_level;
    end else if (ack2 & cfg_q.aeoi) begin
      clr_isr = 8'h01 << ack_level_q;
    end
  end

  // ----------------------------------------
  // initialisation sequence
  // ----------------------------------------
  // cascade word is skipped: second word goes on to fourth or ready
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= pic_pkg::ST_READY;
    end else if (ce_i) begin
      if (w1) begin
        state_q <= pic_pkg::ST_WAIT_W2;
      end else if (wr_data) begin
        unique case (state_q)
          pic_pkg::ST_WAIT_W2: state_q <= cfg_q.need4 ? pic_pkg::ST_WAIT_W4 : pic_pkg::ST_READY;
          pic_pkg::ST_WAIT_W4: state_q <= pic_pkg::ST_READY;
          pic_pkg::ST_READY: state_q <= pic_pkg::ST_READY;
        endcase
      end
    end
  end

  // configuration fields from the initialisation words
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= '0;
      cfg_q.base <= pic_pkg::BASE_RST;
    end else if (ce_i) begin
      if (w1) begin
        cfg_q.level <= d[pic_pkg::W1_LEVEL];
        cfg_q.interval4 <= d[pic_pkg::W1_INTERVAL];
        cfg_q.single <= d[pic_pkg::W1_SINGLE];
        cfg_q.need4 <= d[pic_pkg::W1_NEED4];
        cfg_q.sfnm <= 1'b0;
        cfg_q.buffered <= 1'b0;
        cfg_q.master <= 1'b0;
        cfg_q.aeoi <= 1'b0;
      end else if (wr_data && state_q == pic_pkg::ST_WAIT_W2) begin
        cfg_q.base <= d[7:3];
      end else if (wr_data && state_q == pic_pkg::ST_WAIT_W4) begin
        cfg_q.sfnm <= d[pic_pkg::W4_SFNM];
        cfg_q.buffered <= d[pic_pkg::W4_BUF];
        cfg_q.master <= d[pic_pkg::W4_MASTER] & d[pic_pkg::W4_BUF];
        cfg_q.aeoi <= d[pic_pkg::W4_AEOI];
      end
    end
  end

  // ----------------------------------------
  // mask register
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= pic_pkg::MASK_RST;
    end else if (ce_i) begin
      if (w1) begin
        mask_q <= pic_pkg::MASK_INIT;
      end else if (wr_data && state_q == pic_pkg::ST_READY) begin
        mask_q <= d;
      end
    end
  end

  // ----------------------------------------
  // request latches, one per input
  // ----------------------------------------
  for (genvar n = 0; n < 8; n++) begin : g_req
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        irr_q[n] <= 1'b0;
        prev_q[n] <= 1'b0;
      end else if (ce_i) begin
        prev_q[n] <= request_input_i[n];
        if (cfg_q.level) begin
          irr_q[n] <= request_input_i[n];
        end else if (request_input_i[n] & ~prev_q[n]) begin
          irr_q[n] <= 1'b1;
        end else if (set_isr[n]) begin
          irr_q[n] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // in-service register and rotation
  // ----------------------------------------
  // a new service wins over a clear of the same bit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      in_service_register_q <= 8'h00;
    end else if (ce_i) begin
      if (w1) begin
        in_service_register_q <= 8'h00;
      end else begin
        in_service_register_q <= (in_service_register_q & ~clr_isr) | set_isr;
      end
    end
  end

  // lowest priority level moves with rotate commands
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prio_q <= pic_pkg::PRIO_RST;
      rot_aeoi_q <= 1'b0;
    end else if (ce_i) begin
      if (w1) begin
        prio_q <= pic_pkg::PRIO_RST;
        rot_aeoi_q <= 1'b0;
      end else if (op2 & d[pic_pkg::OP2_ROT] & eoi_hit) begin
        prio_q <= eoi_level;
      end else if (op2 & d[pic_pkg::OP2_SL] & ~d[pic_pkg::OP2_EOI]) begin
        prio_q <= d[2:0];
      end else if (op2 & ~d[pic_pkg::OP2_SL] & ~d[pic_pkg::OP2_EOI]) begin
        rot_aeoi_q <= d[pic_pkg::OP2_ROT];
      end else if (ack2 & cfg_q.aeoi & rot_aeoi_q) begin
        prio_q <= ack_level_q;
      end
    end
  end

  // ----------------------------------------
  // third operation word modes
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      special_mask_state_q <= 1'b0;
      readback_select_in_service_q <= 1'b0;
      poll_q <= 1'b0;
    end else if (ce_i) begin
      if (w1) begin
        special_mask_state_q <= 1'b0;
        readback_select_in_service_q <= 1'b0;
        poll_q <= 1'b0;
      end else if (op3) begin
        if (d[pic_pkg::OP3_SPECIAL_MASK_CHANGE_ENABLE]) begin
          special_mask_state_q <= d[pic_pkg::OP3_SMM];
        end
        if (d[pic_pkg::OP3_RR]) begin
          readback_select_in_service_q <= d[pic_pkg::OP3_RIS];
        end
        poll_q <= d[pic_pkg::OP3_POLL];
      end else if (rd_strobe) begin
        poll_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // acknowledge cycle: first pulse picks, second drives
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_phase_q <= 1'b0;
      ack_level_q <= 3'h7;
    end else if (ce_i) begin
      if (w1) begin
        ack_phase_q <= 1'b0;
      end else if (bus_i.ack) begin
        ack_phase_q <= ~ack_phase_q;
      end
      if (ack1) begin
        ack_level_q <= grant ? top_req[2:0] : 3'h7;
      end
    end
  end

  // ----------------------------------------
  // read data and outputs
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_q <= 8'h00;
      oe_q <= 1'b0;
      buf_q <= 1'b0;
      int_q <= 1'b0;
    end else if (ce_i) begin
      oe_q <= rd_strobe | ack2;
      buf_q <= cfg_q.buffered & (rd_strobe | ack2);
      int_q <= grant & ~ack_phase_q;
      if (rd_strobe) begin
        if (poll_q) begin
          data_q <= {grant, 4'h0, top_req[2:0]};
        end else if (bus_i.a0 == pic_pkg::PORT_DATA[0]) begin
          data_q <= mask_q;
        end else begin
          data_q <= readback_select_in_service_q ? in_service_register_q : irr_q;
        end
      end else if (ack2) begin
        data_q <= {cfg_q.base, ack_level_q};
      end
    end
  end

  assign data_o = data_q;
  assign data_oe_o = oe_q;
  assign buf_en_o = buf_q;
  assign int_o = int_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_w2_done;
    wr_data && !w1 && state_q == pic_pkg::ST_WAIT_W2;
  endsequence
  // a read while a poll command is armed
  sequence s_poll_read;
    rd_strobe && poll_q;
  endsequence

  property p_init_start;
    w1 |=> state_q == pic_pkg::ST_WAIT_W2 && mask_q == 8'h00 && in_service_register_q == 8'h00;
  endproperty
  a_init_start: assert property (p_init_start) else $error("init word did not start sequence");

  property p_level_follow;
    cfg_q.level && !w1 |=> irr_q == $past(request_input_i);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level request not followed");

  property p_w1_fields;
    w1 |=> cfg_q.interval4 == $past(d[2]) && cfg_q.single == $past(d[1]) && cfg_q.need4 == $past(d[0]);
  endproperty
  a_w1_fields: assert property (p_w1_fields) else $error("first word fields not stored");

  property p_w4_follow;
    s_w2_done |=> (state_q == pic_pkg::ST_WAIT_W4) == $past(cfg_q.need4);
  endproperty
  a_w4_follow: assert property (p_w4_follow) else $error("fourth word not expected or skipped");

  property p_base;
    s_w2_done |=> cfg_q.base == $past(d[7:3]);
  endproperty
  a_base: assert property (p_base) else $error("type base not stored");

  property p_type;
    ack2 |=> data_oe_o && data_o == {$past(cfg_q.base), $past(ack_level_q)};
  endproperty
  a_type: assert property (p_type) else $error("wrong type byte on acknowledge");

  property p_mask;
    wr_data && !w1 && state_q == pic_pkg::ST_READY |=> mask_q == $past(d);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not loaded");

  property p_ack_set;
    ack1 && grant |=> in_service_register_q[$past(top_req[2:0])];
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("in-service bit not set");

  property p_eoi_clear;
    eoi_hit && !w1 && !(serve && grant && set_isr == clr_isr) |=> !in_service_register_q[$past(eoi_level)];
  endproperty
  a_eoi_clear: assert property (p_eoi_clear) else $error("end of service did not clear");

  property p_poll;
    s_poll_read |=> data_oe_o && data_o == {$past(grant), 4'h0, $past(top_req[2:0])};
  endproperty
  a_poll: assert property (p_poll) else $error("poll read wrong");

  property p_no_int;
    (irr_q & ~mask_q) == 8'h00 |=> !int_o;
  endproperty
  a_no_int: assert property (p_no_int) else $error("request with nothing pending");

endmodule : pic_core

// ===== pkg/pic_pkg.sv
// package: port decode, command word fields, states and carriers of the interrupt controller
package pic_pkg;

  // ----------------------------------------
  // port offsets, only the low address bit reaches the block
  // ----------------------------------------
  localparam logic [7:0] PORT_CMD = 8'h20;
  localparam logic [7:0] PORT_DATA = 8'h21;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int W1_ID = 4;
  localparam int W1_LEVEL = 3;
  localparam int W1_INTERVAL = 2;
  localparam int W1_SINGLE = 1;
  localparam int W1_NEED4 = 0;
  localparam int W4_SFNM = 4;
  localparam int W4_BUF = 3;
  localparam int W4_MASTER = 2;
  localparam int W4_AEOI = 1;
  localparam int OP_SEL = 3;
  localparam int OP2_ROT = 7;
  localparam int OP2_SL = 6;
  localparam int OP2_EOI = 5;
  localparam int OP3_SPECIAL_MASK_CHANGE_ENABLE = 6;
  localparam int OP3_SMM = 5;
  localparam int OP3_POLL = 2;
  localparam int OP3_RR = 1;
  localparam int OP3_RIS = 0;

  // ----------------------------------------
  // reset and initialisation values
  // ----------------------------------------
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] MASK_INIT = 8'h00;
  localparam logic [2:0] PRIO_RST = 3'h7;
  localparam logic [4:0] BASE_RST = 5'h00;

  // ----------------------------------------
  // states and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {ST_READY, ST_WAIT_W2, ST_WAIT_W4} pic_state_type;

  typedef struct packed {
    logic sel;
    logic a0;
    logic wr;
    logic rd;
    logic ack;
    logic [7:0] data;
  } pic_bus_type;

  typedef struct packed {
    logic level;
    logic interval4;
    logic single;
    logic need4;
    logic sfnm;
    logic buffered;
    logic master;
    logic aeoi;
    logic [4:0] base;
  } pic_cfg_type;

endpackage : pic_pkg

// ===== verif/pic_host.sv
// host processor model driving the controller's processor port
`timescale 1ns/100ps

module pic_host (
  // clock
  input wire logic clock_i,
  // processor port
  output pic_pkg::pic_bus_type bus_o,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  input wire logic buf_en_i
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial begin
    bus_o = '0;
  end

  // one strobe cycle; a released data line shows the inverse of its last value
  task automatic pulse(input logic [4:0] ctl, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    bus_o = {ctl, d};
    @(posedge clock_i);
    #1;
    bus_o = {5'h00, ~d};
  endtask : pulse

  // wait a few cycles at most for the answer strobe, then take the byte
  task automatic answer(output logic [7:0] d, output logic b);
    int n;
    n = 0;
    while (data_oe_i !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    d = (data_oe_i === 1'b1) ? data_i : 8'hxx;
    b = buf_en_i;
  endtask : answer

  // register write: sel, port bit, write strobe
  task automatic wr(input logic a0, input logic [7:0] d);
    pulse({1'b1, a0, 3'b100}, d);
  endtask : wr

  // register read: sel, port bit, read strobe
  task automatic rd(input logic a0, output logic [7:0] d, output logic b);
    pulse({1'b1, a0, 3'b010}, ~bus_o.data);
    answer(d, b);
  endtask : rd

  // acknowledge cycle: two pulses, type byte follows the second
  task automatic ack(output logic [7:0] d, output logic b);
    pulse(5'h01, ~bus_o.data);
    pulse(5'h01, ~bus_o.data);
    answer(d, b);
  endtask : ack
endmodule : pic_host

// ===== verif/tb_priority_interrupt_controller.sv
// self-checking testbench of the priority interrupt controller
`timescale 1ns/100ps

module tb_priority_interrupt_controller;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] request_input_i = 8'h00;
  logic ce_i = 1'b1;
  pic_pkg::pic_bus_type bus;
  logic [7:0] data_o;
  logic data_oe_o;
  logic buf_en_o;
  logic int_o;
  logic [7:0] got;
  logic bf;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clock_i = ~clock_i;

  pic_core u_dut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .bus_i(bus),
    .data_o(data_o),
    .data_oe_o(data_oe_o),
    .buf_en_o(buf_en_o),
    .request_input_i(request_input_i),
    .int_o(int_o)
  );

  pic_host u_host (
    .clock_i(clock_i),
    .bus_o(bus),
    .data_i(data_o),
    .data_oe_i(data_oe_o),
    .buf_en_i(buf_en_o)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic wr(input logic a0, input logic [7:0] d);
    u_host.wr(a0, d);
  endtask : wr

  task automatic rd(input logic a0, input logic [7:0] e);
    u_host.rd(a0, got, bf);
    check(got, e);
  endtask : rd

  // select the in-service register, then read it
  task automatic rd_is(input logic [7:0] e);
    wr(1'b0, 8'h0b);
    rd(1'b0, e);
  endtask : rd_is

  task automatic ack(input logic [7:0] e, input logic eb);
    u_host.ack(got, bf);
    check(got, e);
    check({7'h00, bf}, {7'h00, eb});
  endtask : ack

  task automatic req(input logic [7:0] v);
    @(posedge clock_i);
    #1;
    request_input_i = v;
  endtask : req

  // request output is registered; three cycles cover its latency
  task automatic int_chk(input logic e);
    repeat (3) @(posedge clock_i);
    #1;
    check({7'h00, int_o}, {7'h00, e});
  endtask : int_chk

  // cut a hang short
  always @(posedge clock_i) begin
    cycles++;
    if (cycles >= 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    check({6'h00, int_o, data_oe_o}, 8'h00);
    #1;
    rst_i = 1'b0;
    rd(1'b1, 8'hff);
    // edge inputs, single, fourth word follows
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h0f);
    wr(1'b1, 8'h01);
    rd(1'b1, 8'h00);
    wr(1'b1, 8'hf7);
    rd(1'b1, 8'hf7);
    req(8'h28);
    int_chk(1'b1);
    ack(8'h0b, 1'b0);
    rd_is(8'h08);
    wr(1'b0, 8'h0a);
    rd(1'b0, 8'h20);
    wr(1'b1, 8'h00);
    int_chk(1'b0);
    req(8'h2a);
    int_chk(1'b1);
    ack(8'h09, 1'b0);
    rd_is(8'h0a);
    wr(1'b0, 8'h23);
    rd_is(8'h08);
    wr(1'b0, 8'h63);
    rd_is(8'h00);
    int_chk(1'b1);
    ack(8'h0d, 1'b0);
    wr(1'b0, 8'h20);
    rd_is(8'h00);
    req(8'h6a);
    wr(1'b0, 8'h0c);
    rd(1'b0, 8'h86);
    rd_is(8'h40);
    wr(1'b0, 8'h20);
    // level inputs, no fourth word
    wr(1'b0, 8'h1a);
    wr(1'b1, 8'h10);
    wr(1'b1, 8'hfe);
    rd(1'b1, 8'hfe);
    req(8'h01);
    int_chk(1'b1);
    ack(8'h10, 1'b0);
    wr(1'b0, 8'h20);
    int_chk(1'b1);
    req(8'h00);
    int_chk(1'b0);
    // buffered, automatic end of service
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h20);
    wr(1'b1, 8'h0b);
    wr(1'b1, 8'h00);
    req(8'h10);
    int_chk(1'b1);
    ack(8'h24, 1'b1);
    rd_is(8'h00);
    // lowest level set to 4: level 5 now outranks level 3
    wr(1'b0, 8'hc4);
    req(8'h00);
    req(8'h28);
    ack(8'h25, 1'b1);
    ack(8'h23, 1'b1);
    // a write while the clock enable is low must not land
    ce_i = 1'b0;
    wr(1'b1, 8'h55);
    ce_i = 1'b1;
    rd(1'b1, 8'h00);
    print_verdict();
  end
endmodule : tb_priority_interrupt_controller
